// file: src/adc_seq_pkg.sv
package adc_seq_pkg;

  // ==========================================================
  // Sizes.
  localparam int NUM_SEQ = 4;
  localparam int SEQ_ID_W = 2;
  localparam int RANK_W = 2;
  localparam int RANK_STRIDE = 4;
  localparam int DATA_W = 16;
  localparam int EV_W = 8;

  // ==========================================================
  // Register byte offsets.
  localparam logic [7:0] UFLOW_OFS = 8'h18;
  localparam logic [7:0] PRIO_OFS = 8'h20;
  localparam logic [7:0] INT_STAT_OFS = 8'h24;
  localparam logic [7:0] INT_EN_OFS = 8'h2C;
  localparam logic [7:0] INT_CLR_OFS = 8'h34;
  localparam logic [7:0] RUN_STAT_OFS = 8'h38;

  // ==========================================================
  // Reset values and writable field masks.
  localparam logic [31:0] PRIO_RST = 32'h0000_3210;
  localparam logic [31:0] PRIO_MASK = 32'h0000_3333;
  localparam logic [3:0] UFLOW_RST = 4'h0;
  localparam logic [7:0] INT_RST = 8'h00;

  // ==========================================================
  // Types.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;

  typedef struct packed {
    logic req;
    logic [SEQ_ID_W-1:0] sel;
  } fifo_rd_req_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  // Rank code of one sequencer out of the priority word.
  function automatic logic [RANK_W-1:0] rank_of(input logic [31:0] prio,
                                                input int idx);
    rank_of = prio[idx*RANK_STRIDE +: RANK_W];
  endfunction

endpackage

// file: src/seq_rank_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module seq_rank_arbiter (
  input wire logic [adc_seq_pkg::NUM_SEQ-1:0] pending,
  input wire logic [31:0] prio,
  output logic grant_valid,
  output logic [adc_seq_pkg::SEQ_ID_W-1:0] grant_id
);

  logic [adc_seq_pkg::RANK_W-1:0] best;

  // Lowest rank code among pending sequencers wins; ties keep lower index.
  always_comb begin
    grant_valid = 1'b0;
    grant_id = '0;
    best = '1;
    for (int i = 0; i < adc_seq_pkg::NUM_SEQ; i++) begin
      if (pending[i] && (!grant_valid ||
          adc_seq_pkg::rank_of(prio, i) < best)) begin
        grant_valid = 1'b1;
        grant_id = i[adc_seq_pkg::SEQ_ID_W-1:0];
        best = adc_seq_pkg::rank_of(prio, i);
      end
    end
  end

endmodule
`default_nettype wire

// file: src/empty_read_guard.sv
`timescale 1ns/1ps
`default_nettype none
module empty_read_guard #(
  parameter int DATA_W = adc_seq_pkg::DATA_W
) (
  input wire adc_seq_pkg::fifo_rd_req_t rd_req,
  input wire logic [adc_seq_pkg::NUM_SEQ-1:0] fifo_empty,
  input wire logic [adc_seq_pkg::NUM_SEQ*DATA_W-1:0] fifo_data,
  output logic [adc_seq_pkg::NUM_SEQ-1:0] fifo_pop,
  output logic [adc_seq_pkg::NUM_SEQ-1:0] uflow_set,
  output logic [DATA_W-1:0] data_nxt
);

  // Per sequencer: pop only a non-empty FIFO, flag a read of an empty one.
  for (genvar g = 0; g < adc_seq_pkg::NUM_SEQ; g++) begin : g_seq
    logic hit;
    assign hit = rd_req.req && (int'(rd_req.sel) == g);
    assign fifo_pop[g] = hit && !fifo_empty[g];
    assign uflow_set[g] = hit && fifo_empty[g];
  end

  // An empty FIFO answers with zeros instead of its stale head word.
  assign data_nxt = fifo_empty[rd_req.sel] ? '0 :
                    fifo_data[rd_req.sel*DATA_W +: DATA_W];

endmodule
`default_nettype wire

// file: src/adc_seq_underflow_priority.sv
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_underflow_priority #(
  parameter int DATA_W = adc_seq_pkg::DATA_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [adc_seq_pkg::NUM_SEQ-1:0] trig_in,
  output logic seq_start,
  output logic [adc_seq_pkg::SEQ_ID_W-1:0] seq_id,
  input wire logic conv_done,
  output logic busy,
  input wire adc_seq_pkg::fifo_rd_req_t rd_req,
  input wire logic [adc_seq_pkg::NUM_SEQ-1:0] fifo_empty,
  input wire logic [adc_seq_pkg::NUM_SEQ*DATA_W-1:0] fifo_data,
  output logic [adc_seq_pkg::NUM_SEQ-1:0] fifo_pop,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic irq
);

  localparam int N = adc_seq_pkg::NUM_SEQ;
  localparam int EVW = adc_seq_pkg::EV_W;

  // True when the bus address selects the given register.
  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction

  // Expands byte selects into a bit mask.
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      lane_mask[8*b +: 8] = {8{sel[b]}};
    end
  endfunction

  // One-hot vector for a sequencer number.
  function automatic logic [N-1:0] onehot(
      input logic [adc_seq_pkg::SEQ_ID_W-1:0] id);
    onehot = '0;
    onehot[id] = 1'b1;
  endfunction

  // ==========================================================
  // Bus slave.
  adc_seq_pkg::wb_req_t bus;
  logic acc;
  logic wr_acc;
  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic [31:0] be_mask;

  // Register state.
  logic [N-1:0] uflow_r;
  logic [N-1:0] uflow_set;
  logic [N-1:0] uflow_clr;
  logic [31:0] prio_r;
  logic [31:0] prio_wmask;
  logic [EVW-1:0] int_stat_r;
  logic [EVW-1:0] int_en_r;
  logic [EVW-1:0] int_clr;
  logic [EVW-1:0] ev;

  // Sequencing state.
  adc_seq_pkg::run_state_t state_r;
  logic [N-1:0] pending_r;
  logic [N-1:0] grant_clr;
  logic [N-1:0] done_ev;
  logic grant_valid;
  logic [adc_seq_pkg::SEQ_ID_W-1:0] grant_id;
  logic start_now;
  logic seq_start_r;
  logic [adc_seq_pkg::SEQ_ID_W-1:0] seq_id_r;

  // Read path.
  logic [DATA_W-1:0] rd_data_nxt;
  logic [DATA_W-1:0] rd_data_r;
  logic rd_valid_r;

  // Pack the bus request; ack comes one cycle after a new request.
  assign bus = {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i};
  assign acc = bus.cyc && bus.stb && !ack_r;
  assign wr_acc = acc && bus.we;
  assign be_mask = lane_mask(bus.sel);
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Ack is a single cycle; a held request is not taken twice.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  // Read mux; unmapped and write-only offsets read as zero.
  always_comb begin
    case (bus.adr)
      adc_seq_pkg::UFLOW_OFS: dat_nxt = {28'h0000000, uflow_r};
      adc_seq_pkg::PRIO_OFS: dat_nxt = prio_r & adc_seq_pkg::PRIO_MASK;
      adc_seq_pkg::INT_STAT_OFS: dat_nxt = {24'h000000, int_stat_r};
      adc_seq_pkg::INT_EN_OFS: dat_nxt = {24'h000000, int_en_r};
      adc_seq_pkg::RUN_STAT_OFS: begin
        dat_nxt = {25'h0, pending_r, busy, seq_id_r};
      end
      default: dat_nxt = 32'h00000000;
    endcase
  end

  // Read data is captured when the request is taken.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dat_r <= 32'h00000000;
    end else if (acc && !bus.we) begin
      dat_r <= dat_nxt;
    end
  end

  // ==========================================================
  // Underflow flags.
  empty_read_guard #(
    .DATA_W(DATA_W)
  ) u_guard (
    .rd_req(rd_req),
    .fifo_empty(fifo_empty),
    .fifo_data(fifo_data),
    .fifo_pop(fifo_pop),
    .uflow_set(uflow_set),
    .data_nxt(rd_data_nxt)
  );

  // Write-one-to-clear on the low lane only; upper bits have no storage.
  always_comb begin
    uflow_clr = '0;
    if (wr_acc && hit(bus.adr, adc_seq_pkg::UFLOW_OFS)) begin
      uflow_clr = bus.dat[N-1:0] & be_mask[N-1:0];
    end
  end

  // A flag set in the clearing cycle survives the clear.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      uflow_r <= adc_seq_pkg::UFLOW_RST;
    end else begin
      uflow_r <= (uflow_r & ~uflow_clr) | uflow_set;
    end
  end

  // Read data to the requester, zero for an empty FIFO.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_req.req;
      if (rd_req.req) begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;

  // ==========================================================
  // Priority register.
  assign prio_wmask = be_mask & adc_seq_pkg::PRIO_MASK;

  // Only the four rank fields store; reserved bits stay zero.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prio_r <= adc_seq_pkg::PRIO_RST;
    end else if (wr_acc && hit(bus.adr, adc_seq_pkg::PRIO_OFS)) begin
      prio_r <= (prio_r & ~prio_wmask) | (bus.dat & prio_wmask);
    end
  end

  // ==========================================================
  // Sequencing.
  seq_rank_arbiter u_arb (
    .pending(pending_r),
    .prio(prio_r),
    .grant_valid(grant_valid),
    .grant_id(grant_id)
  );

  assign start_now = (state_r == adc_seq_pkg::ST_IDLE) && grant_valid;
  assign grant_clr = start_now ? onehot(grant_id) : '0;
  assign done_ev = (state_r == adc_seq_pkg::ST_RUN && conv_done) ?
                   onehot(seq_id_r) : '0;

  // Triggers queue up; a retrigger on grant stays pending.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pending_r <= '0;
    end else begin
      pending_r <= (pending_r & ~grant_clr) | trig_in;
    end
  end

  // One sequence runs at a time, the best-ranked pending one next.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= adc_seq_pkg::ST_IDLE;
    end else begin
      case (state_r)
        adc_seq_pkg::ST_IDLE: begin
          if (start_now) begin
            state_r <= adc_seq_pkg::ST_RUN;
          end
        end
        adc_seq_pkg::ST_RUN: begin
          if (conv_done) begin
            state_r <= adc_seq_pkg::ST_IDLE;
          end
        end
        default: state_r <= adc_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // Start pulse and the number of the sequence being run.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seq_start_r <= 1'b0;
      seq_id_r <= '0;
    end else begin
      seq_start_r <= start_now;
      if (start_now) begin
        seq_id_r <= grant_id;
      end
    end
  end

  assign seq_start = seq_start_r;
  assign seq_id = seq_id_r;
  assign busy = (state_r == adc_seq_pkg::ST_RUN);

  // ==========================================================
  // Interrupts: underflow events low, sequence-done events high.
  assign ev = {done_ev, uflow_set};

  always_comb begin
    int_clr = '0;
    if (wr_acc && hit(bus.adr, adc_seq_pkg::INT_CLR_OFS)) begin
      int_clr = bus.dat[EVW-1:0] & be_mask[EVW-1:0];
    end
  end

  // Sticky status, enable register, set wins over clear.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      int_stat_r <= adc_seq_pkg::INT_RST;
      int_en_r <= adc_seq_pkg::INT_RST;
    end else begin
      int_stat_r <= (int_stat_r & ~int_clr) | ev;
      if (wr_acc && hit(bus.adr, adc_seq_pkg::INT_EN_OFS)) begin
        int_en_r <= (int_en_r & ~be_mask[EVW-1:0]) |
                    (bus.dat[EVW-1:0] & be_mask[EVW-1:0]);
      end
    end
  end

  assign irq = |(int_stat_r & int_en_r);

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [adc_seq_pkg::RANK_W-1:0] win_rank;
  logic better_exists;

  // Flags a pending sequencer that outranks the one being granted.
  always_comb begin
    win_rank = adc_seq_pkg::rank_of(prio_r, int'(grant_id));
    better_exists = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (pending_r[i] && adc_seq_pkg::rank_of(prio_r, i) < win_rank) begin
        better_exists = 1'b1;
      end
    end
  end

  AST_UFLOW_SET: assert property (
    rd_req.req && fifo_empty[rd_req.sel] |=> uflow_r[$past(rd_req.sel)])
    else $error("Empty read did not set its underflow flag.");

  AST_NO_POP_EMPTY: assert property (
    (fifo_pop & fifo_empty) == '0 && $onehot0(fifo_pop))
    else $error("Empty FIFO was popped.");

  AST_ZERO_DATA: assert property (
    rd_req.req && fifo_empty[rd_req.sel] |=> rd_valid && rd_data == '0)
    else $error("Empty read returned non-zero data.");

  // Skipped right after reset, which legally drops every flag.
  AST_UFLOW_STICKY: assert property (
    $past(rst) || (~uflow_r & $past(uflow_r) & ~$past(uflow_clr)) == '0)
    else $error("Underflow flag dropped without a write of one.");

  AST_UFLOW_READ: assert property (
    acc && !bus.we && hit(bus.adr, adc_seq_pkg::UFLOW_OFS)
    |=> wb_ack_o && wb_dat_o[31:4] == 28'h0000000 &&
        wb_dat_o[3:0] == $past(uflow_r))
    else $error("Underflow status read back wrong.");

  AST_PRIO_WRITE: assert property (
    wr_acc && hit(bus.adr, adc_seq_pkg::PRIO_OFS) && bus.sel == 4'hF
    |=> prio_r == ($past(bus.dat) & adc_seq_pkg::PRIO_MASK))
    else $error("Priority write not stored as written.");

  AST_RANK_ORDER: assert property (
    start_now |-> !better_exists ##1 seq_start && seq_id == $past(grant_id))
    else $error("A worse-ranked sequencer was started first.");

  AST_PRIO_RESET: assert property (
    $past(rst) |-> prio_r == adc_seq_pkg::PRIO_RST &&
                   uflow_r == adc_seq_pkg::UFLOW_RST)
    else $error("Reset values wrong.");

  // Done may come the cycle after start; no start while running.
  AST_ONE_AT_A_TIME: assert property (
    (seq_start |-> busy) and (busy |=> !seq_start))
    else $error("A second sequence started while one was running.");

  AST_PRIO_RSV: assert property (
    (prio_r & ~adc_seq_pkg::PRIO_MASK) == 32'h00000000)
    else $error("Reserved priority bits hold a value.");

  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("Bus ack held longer than one cycle.");

  COV_UFLOW: cover property (rd_req.req && fifo_empty[rd_req.sel]);
  COV_MULTI_TRIG: cover property (start_now && $countones(pending_r) > 1);
  COV_CLR_SET: cover property ((uflow_clr & uflow_set) != '0);
  COV_IRQ: cover property ($rose(irq));

endmodule
`default_nettype wire

// file: testbench/adc_seq_underflow_priority_test.sv
`timescale 1ns/1ps
`default_nettype none
module adc_seq_underflow_priority_test;
  // ==========================================================
  // Stimulus, observed outputs and counters.
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] trig_in = 4'h0;
  logic seq_start;
  logic [1:0] seq_id;
  logic conv_done = 1'b0;
  logic busy;
  adc_seq_pkg::fifo_rd_req_t rd_req = '0;
  logic [3:0] fifo_empty = 4'h0;
  logic [63:0] fifo_data = 64'h0;
  logic [3:0] fifo_pop;
  logic [15:0] rd_data;
  logic rd_valid;
  logic irq;
  int fail_count = 0;
  int checks = 0;
  logic [3:0] uflow_m = 4'h0;
  logic [1:0] rank [4];
  logic [31:0] rdat;
  logic [31:0] w;
  logic [1:0] t;
  int j;

  // The clock toggles every 50 ns, a half period of the 100 ns period.
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  adc_seq_underflow_priority dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .trig_in(trig_in),
    .seq_start(seq_start),
    .seq_id(seq_id),
    .conv_done(conv_done),
    .busy(busy),
    .rd_req(rd_req),
    .fifo_empty(fifo_empty),
    .fifo_data(fifo_data),
    .fifo_pop(fifo_pop),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .irq(irq)
  );

  // ==========================================================
  // Reporting helpers.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up();
    fail_count++;
    $display("BAD wait expected 1 seen 0");
    report_and_stop();
  endtask

  // Sequencer holding rank r in the current rank table.
  function automatic logic [1:0] who_ranked(input logic [1:0] r);
    who_ranked = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (rank[i] == r) who_ranked = 2'(i);
    end
  endfunction

  // ==========================================================
  // Bus and port drivers.
  // One classic cycle; request held until ack is sampled high.
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
                         input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) give_up();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // One result read from sequencer s, its FIFO empty when e is set.
  task automatic rd_probe(input logic [1:0] s, input logic e);
    logic [63:0] d;
    logic [15:0] exp;
    d = {$urandom, $urandom};
    exp = e ? 16'h0000 : d[s*16 +: 16];
    @(posedge sys_clk);
    rd_req.req <= 1'b1;
    rd_req.sel <= s;
    fifo_empty <= 4'($urandom) & ~(4'h1 << s) | ({3'h0, e} << s);
    fifo_data <= d;
    @(negedge sys_clk);
    check("fifo_pop", {28'h0, e ? 4'h0 : 4'h1 << s},
          {28'h0, fifo_pop});
    @(posedge sys_clk);
    rd_req.req <= 1'b0;
    @(negedge sys_clk);
    check("rd_valid", 32'h1, {31'h0, rd_valid});
    check("rd_data", {16'h0, exp}, {16'h0, rd_data});
    if (e) uflow_m[s] = 1'b1;
  endtask

  // Trigger all four at once and follow the start order.
  task automatic run_order();
    int n;
    @(posedge sys_clk);
    trig_in <= 4'hF;
    @(posedge sys_clk);
    trig_in <= 4'h0;
    for (int k = 0; k < 4; k++) begin
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (seq_start !== 1'b1 && n < 20);
      if (seq_start !== 1'b1) give_up();
      check("seq_id", {30'h0, who_ranked(k[1:0])},
            {30'h0, seq_id});
      check("busy", 32'h1, {31'h0, busy});
      @(posedge sys_clk);
      conv_done <= 1'b1;
      @(posedge sys_clk);
      conv_done <= 1'b0;
    end
    repeat (3) @(negedge sys_clk);
    check("busy idle", 32'h0, {31'h0, busy});
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    void'($urandom(85280));
    for (int i = 0; i < 4; i++) rank[i] = 2'(i);
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    wb_xfer(1'b0, adc_seq_pkg::UFLOW_OFS, 32'h0, rdat);
    check("uflow reset", 32'h0, rdat);
    wb_xfer(1'b0, adc_seq_pkg::PRIO_OFS, 32'h0, rdat);
    check("prio reset", 32'h0000_3210, rdat);
    wb_xfer(1'b0, 8'h3C, 32'h0, rdat);
    check("unmapped", 32'h0, rdat);
    run_order();
    // Idle, nothing pending, last started is the worst-ranked one.
    wb_xfer(1'b0, adc_seq_pkg::RUN_STAT_OFS, 32'h0, rdat);
    check("run stat", {30'h0, who_ranked(2'h3)}, rdat);
    $display("test reset done");
    // Random reads, then an empty read on every sequencer.
    for (int i = 0; i < 12; i++) rd_probe(2'($urandom), 1'($urandom));
    for (int i = 0; i < 4; i++) rd_probe(2'(i), 1'b1);
    rd_probe(2'h3, 1'b0);
    wb_xfer(1'b0, adc_seq_pkg::UFLOW_OFS, 32'h0, rdat);
    check("uflow set", {28'h0, uflow_m}, rdat);
    $display("test empty reads done");
    // Zeros keep flags, ones clear them, high bits stay zero.
    wb_xfer(1'b1, adc_seq_pkg::UFLOW_OFS, 32'h0, rdat);
    wb_xfer(1'b0, adc_seq_pkg::UFLOW_OFS, 32'h0, rdat);
    check("uflow hold", 32'hF, rdat);
    wb_xfer(1'b1, adc_seq_pkg::UFLOW_OFS, 32'hFFFF_FFF5, rdat);
    wb_xfer(1'b0, adc_seq_pkg::UFLOW_OFS, 32'h0, rdat);
    check("uflow clear", 32'hA, rdat);
    wb_xfer(1'b1, adc_seq_pkg::UFLOW_OFS, 32'hA, rdat);
    wb_xfer(1'b0, adc_seq_pkg::UFLOW_OFS, 32'h0, rdat);
    check("uflow empty", 32'h0, rdat);
    $display("test clear done");
    // Earlier events are still latched; clear them before the irq test.
    wb_xfer(1'b0, adc_seq_pkg::INT_STAT_OFS, 32'h0, rdat);
    check("int stat all", 32'hFF, rdat);
    wb_xfer(1'b1, adc_seq_pkg::INT_CLR_OFS, 32'hFF, rdat);
    // Interrupt raised, cleared, then masked.
    wb_xfer(1'b1, adc_seq_pkg::INT_EN_OFS, 32'h0F, rdat);
    rd_probe(2'h1, 1'b1);
    repeat (2) @(negedge sys_clk);
    check("irq set", 32'h1, {31'h0, irq});
    wb_xfer(1'b1, adc_seq_pkg::INT_CLR_OFS, 32'h02, rdat);
    repeat (2) @(negedge sys_clk);
    check("irq clear", 32'h0, {31'h0, irq});
    wb_xfer(1'b1, adc_seq_pkg::INT_EN_OFS, 32'h00, rdat);
    rd_probe(2'h2, 1'b1);
    repeat (2) @(negedge sys_clk);
    check("irq masked", 32'h0, {31'h0, irq});
    wb_xfer(1'b0, adc_seq_pkg::INT_STAT_OFS, 32'h0, rdat);
    check("int stat", 32'h04, rdat);
    wb_xfer(1'b1, adc_seq_pkg::INT_CLR_OFS, 32'hFF, rdat);
    $display("test interrupt done");
    // Shuffled distinct ranks with junk in the reserved bits.
    repeat (3) begin
      for (int i = 3; i > 0; i--) begin
        j = $urandom % (i + 1);
        t = rank[i];
        rank[i] = rank[j];
        rank[j] = t;
      end
      w = $urandom & ~adc_seq_pkg::PRIO_MASK;
      for (int i = 0; i < 4; i++) w[i*4 +: 2] = rank[i];
      wb_xfer(1'b1, adc_seq_pkg::PRIO_OFS, w, rdat);
      wb_xfer(1'b0, adc_seq_pkg::PRIO_OFS, 32'h0, rdat);
      check("prio", w & adc_seq_pkg::PRIO_MASK, rdat);
      run_order();
    end
    wb_xfer(1'b0, adc_seq_pkg::INT_STAT_OFS, 32'h0, rdat);
    check("done events", 32'hF0, rdat);
    $display("test priority done");
    report_and_stop();
  end
endmodule
`default_nettype wire
